// *** design/pwr_nvm_defines.svh ***
// Offsets, field positions, reset values and timing in microseconds
`ifndef PWR_NVM_DEFINES_SVH
`define PWR_NVM_DEFINES_SVH
`define CLK_MHZ 25
`define ADDR_SPEED_COMMAND 8'h30
`define ADDR_NVM_UNLOCK_KEY 8'h31
`define ADDR_NVM_STATUS 8'h32
`define ADDR_NVM_OP_CONTROL 8'h35
`define ADDR_DRIVER_NVM_CONTROL 8'h60
`define ADDR_MOTOR_CONFIG_FIRST 8'h90
`define ADDR_MOTOR_CONFIG_LAST 8'h96
`define NVM_WORDS 7
`define KEY_CLEAR 16'h0000
`define KEY_OPEN 16'hC0DE
`define SPEED_FIELD_MSB 8
`define HOST_SPEED_BIT 15
`define MOTOR_DISABLE_BIT 15
`define STATUS_READY_BIT 0
`define STATUS_UNLOCKED_BIT 1
`define STATUS_LOWPWR_BIT 2
`define ACCESS_MODE_MASS 2'h2
`define REG_RESET 16'h0000
`define NVM_DEFAULT 16'h0000
`define T_ENTER_ANA_US 1000
`define T_ENTER_PWM_US 1000
`define T_EXIT_ANA_US 1000
`define T_EXIT_PWM_US 1000
`define T_NVM_WRITE_US 100
`endif

// *** design/pwr_nvm_pkg.sv ***
// Types shared by the power state and nonvolatile access block
package pwr_nvm_pkg;
	typedef enum logic [1:0] {
		MODE_ANALOG = 2'b00,
		MODE_PWM = 2'b01,
		MODE_HOST = 2'b10
	} speed_mode_t;
	typedef enum logic [2:0] {
		ST_RELOAD = 3'b000,
		ST_ACTIVE = 3'b001,
		ST_LOWPWR = 3'b010,
		ST_MASS_READ = 3'b011,
		ST_MASS_WRITE = 3'b100
	} pwr_state_t;
	typedef struct packed {
		logic [9:0] unused;
		logic [1:0] nvm_access_mode;
		logic spare;
		logic nvm_write_not_read;
		logic nvm_reload_trigger;
		logic shadow_register_select;
	} nvm_op_t;
	typedef struct packed {
		logic [2:0] exponent;
		logic [3:0] mantissa;
	} motor_code_t;
	typedef struct packed {
		logic [7:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;
endpackage

// *** design/power_state_and_eeprom_access.sv ***
// Power state control, overvoltage stop and EEPROM mass access
//
// Function
// - Overvoltage stops drive until supply falls back
// - No motor drive while in low power
// - Sleep version: regulator, I2C off, volatile reset
// - Standby version keeps regulator, I2C, registers
// - Pin modes: qualified enter and exit times
// - Host mode standby: speed field zero/non-zero qualified
// - Sleep exit only from qualified speed pin
// - Analog sleep exit uses higher threshold
// - Seven sixteen-bit nonvolatile configuration words
// - Access unlocked by key zero then code
// - Ready flag in status, polled by host
// - Mass write copies shadows, then ready set
// - Mass read loads shadows, then ready set
// - Resistance and BEMF codes, exponent and mantissa
// - Reload from EEPROM at power-on and sleep exit
// - Host-written registers override settings loaded before the write
`timescale 1ns/10ps
`include "pwr_nvm_defines.svh"

module power_state_and_eeprom_access #(
	parameter bit SLEEP_VERSION = 1'b1,
	parameter int QW = 20,
	parameter int ENTER_ANA_CYC = `T_ENTER_ANA_US * `CLK_MHZ,
	parameter int ENTER_PWM_CYC = `T_ENTER_PWM_US * `CLK_MHZ,
	parameter int EXIT_ANA_CYC = `T_EXIT_ANA_US * `CLK_MHZ,
	parameter int EXIT_PWM_CYC = `T_EXIT_PWM_US * `CLK_MHZ,
	parameter int NVM_WRITE_CYC = `T_NVM_WRITE_US * `CLK_MHZ
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Register access from the serial interface decoder
	input wire pwr_nvm_pkg::reg_req_t reg_req,
	output logic [15:0] reg_rdata,
	output logic reg_rvalid,
	// Analog monitor and speed pin comparators
	input wire logic supply_over,
	input wire logic speed_pin_high,
	input wire logic speed_below_enter,
	input wire logic speed_above_exit_standby,
	input wire logic speed_above_exit_sleep,
	// Speed source selected by the configuration
	input wire pwr_nvm_pkg::speed_mode_t speed_mode,
	// Driver and supply control
	output logic drive_enable,
	output logic regulator_enable,
	output logic serial_enable,
	output logic low_power,
	output logic [8:0] speed_command_field,
	output pwr_nvm_pkg::motor_code_t phase_resistance_code,
	output pwr_nvm_pkg::motor_code_t bemf_constant_code
);
	localparam int WI = 3;

	// QW kept below 31 so that 2 ** QW still fits an int
	if (QW < 2 || QW > 30) begin : g_qw_check
		$error("QW out of range");
	end
	if (ENTER_ANA_CYC < 1 || ENTER_PWM_CYC < 1 ||
		EXIT_ANA_CYC < 1 || EXIT_PWM_CYC < 1 ||
		NVM_WRITE_CYC < 1 || NVM_WRITE_CYC >= 2 ** QW ||
		ENTER_ANA_CYC >= 2 ** QW || ENTER_PWM_CYC >= 2 ** QW ||
		EXIT_ANA_CYC >= 2 ** QW || EXIT_PWM_CYC >= 2 ** QW) begin : g_cyc_check
		$error("Qualification counts do not fit QW");
	end

	// Pin synchronisers, stage one read only by stage two
	logic [4:0] sync_a;
	logic [4:0] sync_b;
	always_ff @(posedge clk) begin
		if (reset) begin
			sync_a <= 5'h00;
			sync_b <= 5'h00;
		end else begin
			sync_a <= {supply_over, speed_pin_high, speed_below_enter,
				speed_above_exit_standby, speed_above_exit_sleep};
			sync_b <= sync_a;
		end
	end
	logic ov_s, pin_high_s, below_enter_s, above_sb_s, above_sl_s;
	assign {ov_s, pin_high_s, below_enter_s, above_sb_s, above_sl_s} = sync_b;

	// State
	pwr_nvm_pkg::pwr_state_t state, next_state;
	logic [15:0] speed_command, next_speed_command;
	logic [15:0] unlock_key, next_unlock_key;
	logic [15:0] op_control, next_op_control;
	logic [15:0] driver_control, next_driver_control;
	logic key_cleared, next_key_cleared;
	logic unlocked, next_unlocked;
	logic ready, next_ready;
	logic [QW-1:0] qual, next_qual;
	logic [QW-1:0] wait_cnt, next_wait_cnt;
	logic [WI-1:0] word, next_word;
	logic [15:0] shadow [`NVM_WORDS];
	logic [15:0] next_shadow [`NVM_WORDS];
	logic [15:0] nvm [`NVM_WORDS];
	logic [15:0] next_nvm [`NVM_WORDS];
	logic [15:0] next_reg_rdata;
	logic next_reg_rvalid, next_drive_enable, next_low_power;

	// Qualification condition and time for the present state
	logic cond;
	logic [QW-1:0] limit;
	logic field_zero;
	assign field_zero = speed_command[`SPEED_FIELD_MSB:0] == 9'h000;
	always_comb begin
		cond = 1'b0;
		limit = QW'(ENTER_PWM_CYC);
		if (state == pwr_nvm_pkg::ST_ACTIVE) begin
			case (speed_mode)
				pwr_nvm_pkg::MODE_ANALOG: begin
					cond = below_enter_s;
					limit = QW'(ENTER_ANA_CYC);
				end
				pwr_nvm_pkg::MODE_PWM: begin
					cond = !pin_high_s;
				end
				default: begin
					cond = SLEEP_VERSION ?
						(speed_command[`HOST_SPEED_BIT] && field_zero) :
						field_zero;
				end
			endcase
		end else if (state == pwr_nvm_pkg::ST_LOWPWR) begin
			case (speed_mode)
				pwr_nvm_pkg::MODE_ANALOG: begin
					cond = SLEEP_VERSION ? above_sl_s : above_sb_s;
					limit = QW'(EXIT_ANA_CYC);
				end
				pwr_nvm_pkg::MODE_PWM: begin
					cond = pin_high_s;
					limit = QW'(EXIT_PWM_CYC);
				end
				default: begin
					cond = SLEEP_VERSION ? (pin_high_s || above_sl_s) :
						!field_zero;
					limit = QW'(EXIT_PWM_CYC);
				end
			endcase
		end
	end

	logic host_ok, wr_any, is_shadow;
	logic [7:0] shadow_off;
	pwr_nvm_pkg::nvm_op_t op_w;
	assign host_ok = !(SLEEP_VERSION && state == pwr_nvm_pkg::ST_LOWPWR);
	assign wr_any = reg_req.wr && host_ok;
	assign shadow_off = reg_req.addr - `ADDR_MOTOR_CONFIG_FIRST;
	assign is_shadow = reg_req.addr >= `ADDR_MOTOR_CONFIG_FIRST &&
		reg_req.addr <= `ADDR_MOTOR_CONFIG_LAST;
	assign op_w = reg_req.wdata;

	always_comb begin
		next_state = state;
		next_speed_command = speed_command;
		next_unlock_key = unlock_key;
		next_op_control = op_control;
		next_driver_control = driver_control;
		next_key_cleared = key_cleared;
		next_unlocked = unlocked;
		next_ready = ready;
		next_qual = qual;
		next_wait_cnt = wait_cnt;
		next_word = word;
		next_shadow = shadow;
		next_nvm = nvm;
		next_reg_rvalid = reg_req.rd && host_ok;
		next_reg_rdata = 16'h0000;
		// Register writes; the state actions below (load of the current word, sleep-entry reset) win over them
		if (wr_any) begin
			case (reg_req.addr)
				`ADDR_SPEED_COMMAND: next_speed_command = reg_req.wdata;
				`ADDR_NVM_UNLOCK_KEY: begin
					next_unlock_key = reg_req.wdata;
					next_unlocked = key_cleared &&
						reg_req.wdata == `KEY_OPEN;
					next_key_cleared = reg_req.wdata == `KEY_CLEAR;
				end
				`ADDR_NVM_OP_CONTROL: next_op_control = reg_req.wdata;
				`ADDR_DRIVER_NVM_CONTROL: next_driver_control = reg_req.wdata;
				default: begin
					if (is_shadow) begin
						next_shadow[shadow_off[WI-1:0]] = reg_req.wdata;
					end
				end
			endcase
		end
		if (reg_req.rd && host_ok) begin
			case (reg_req.addr)
				`ADDR_SPEED_COMMAND: next_reg_rdata = speed_command;
				`ADDR_NVM_UNLOCK_KEY: next_reg_rdata = unlock_key;
				`ADDR_NVM_STATUS: begin
					next_reg_rdata[`STATUS_READY_BIT] = ready;
					next_reg_rdata[`STATUS_UNLOCKED_BIT] = unlocked;
					next_reg_rdata[`STATUS_LOWPWR_BIT] =
						state == pwr_nvm_pkg::ST_LOWPWR;
				end
				`ADDR_NVM_OP_CONTROL: next_reg_rdata = op_control;
				`ADDR_DRIVER_NVM_CONTROL: next_reg_rdata = driver_control;
				default: begin
					if (is_shadow) begin
						next_reg_rdata = shadow[shadow_off[WI-1:0]];
					end
				end
			endcase
		end
		// Qualification counter
		if (cond) begin
			next_qual = qual + QW'(1);
		end else begin
			next_qual = '0;
		end
		case (state)
			pwr_nvm_pkg::ST_RELOAD: begin
				next_shadow[word] = nvm[word];
				next_qual = '0;
				if (word == WI'(`NVM_WORDS - 1)) begin
					next_word = '0;
					next_ready = 1'b1;
					next_state = pwr_nvm_pkg::ST_ACTIVE;
				end else begin
					next_word = word + WI'(1);
				end
			end
			pwr_nvm_pkg::ST_ACTIVE: begin
				if (cond && qual == limit - QW'(1)) begin
					next_qual = '0;
					next_state = pwr_nvm_pkg::ST_LOWPWR;
					if (SLEEP_VERSION) begin
						next_speed_command = `REG_RESET;
						next_unlock_key = `REG_RESET;
						next_op_control = `REG_RESET;
						next_driver_control = `REG_RESET;
						next_key_cleared = 1'b0;
						next_unlocked = 1'b0;
					end
				end else if (wr_any && reg_req.addr == `ADDR_NVM_OP_CONTROL &&
					op_w.nvm_access_mode == `ACCESS_MODE_MASS &&
					!op_w.shadow_register_select && unlocked && ready) begin
					next_ready = 1'b0;
					next_word = '0;
					next_wait_cnt = '0;
					if (op_w.nvm_write_not_read &&
						!op_w.nvm_reload_trigger) begin
						next_state = pwr_nvm_pkg::ST_MASS_WRITE;
					end else begin
						next_state = pwr_nvm_pkg::ST_MASS_READ;
					end
				end
			end
			pwr_nvm_pkg::ST_LOWPWR: begin
				if (cond && qual == limit - QW'(1)) begin
					next_qual = '0;
					next_state = SLEEP_VERSION ? pwr_nvm_pkg::ST_RELOAD :
						pwr_nvm_pkg::ST_ACTIVE;
				end
			end
			pwr_nvm_pkg::ST_MASS_READ: begin
				next_qual = '0;
				next_shadow[word] = nvm[word];
				if (word == WI'(`NVM_WORDS - 1)) begin
					// Index back to zero so a later reload covers all words
					next_word = '0;
					next_ready = 1'b1;
					next_state = pwr_nvm_pkg::ST_ACTIVE;
				end else begin
					next_word = word + WI'(1);
				end
			end
			pwr_nvm_pkg::ST_MASS_WRITE: begin
				// shadow to nonvolatile, timed per word
				next_qual = '0;
				if (wait_cnt == QW'(NVM_WRITE_CYC - 1)) begin
					next_wait_cnt = '0;
					next_nvm[word] = shadow[word];
					if (word == WI'(`NVM_WORDS - 1)) begin
						next_word = '0;
						next_ready = 1'b1;
						next_state = pwr_nvm_pkg::ST_ACTIVE;
					end else begin
						next_word = word + WI'(1);
					end
				end else begin
					next_wait_cnt = wait_cnt + QW'(1);
				end
			end
			default: next_state = pwr_nvm_pkg::ST_RELOAD;
		endcase
		next_drive_enable = !ov_s && !driver_control[`MOTOR_DISABLE_BIT] &&
			next_state != pwr_nvm_pkg::ST_LOWPWR &&
			next_state != pwr_nvm_pkg::ST_RELOAD;
		next_low_power = next_state == pwr_nvm_pkg::ST_LOWPWR;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state <= pwr_nvm_pkg::ST_RELOAD;
			speed_command <= `REG_RESET;
			unlock_key <= `REG_RESET;
			op_control <= `REG_RESET;
			driver_control <= `REG_RESET;
			key_cleared <= 1'b0;
			unlocked <= 1'b0;
			ready <= 1'b0;
			qual <= '0;
			wait_cnt <= '0;
			word <= '0;
			reg_rdata <= 16'h0000;
			reg_rvalid <= 1'b0;
			drive_enable <= 1'b0;
			low_power <= 1'b0;
			regulator_enable <= 1'b1;
			serial_enable <= 1'b1;
			speed_command_field <= 9'h000;
			phase_resistance_code <= '0;
			bemf_constant_code <= '0;
		end else begin
			state <= next_state;
			speed_command <= next_speed_command;
			unlock_key <= next_unlock_key;
			op_control <= next_op_control;
			driver_control <= next_driver_control;
			key_cleared <= next_key_cleared;
			unlocked <= next_unlocked;
			ready <= next_ready;
			qual <= next_qual;
			wait_cnt <= next_wait_cnt;
			word <= next_word;
			reg_rdata <= next_reg_rdata;
			reg_rvalid <= next_reg_rvalid;
			drive_enable <= next_drive_enable;
			low_power <= next_low_power;
			// sleep drops supply and serial; standby keeps
			regulator_enable <= !(SLEEP_VERSION && next_low_power);
			serial_enable <= !(SLEEP_VERSION && next_low_power);
			speed_command_field <= next_speed_command[`SPEED_FIELD_MSB:0];
			phase_resistance_code <= next_shadow[0][6:0];
			bemf_constant_code <= next_shadow[1][6:0];
		end
	end

	// seven words of storage in flip-flops
	genvar gi;
	generate
		for (gi = 0; gi < `NVM_WORDS; gi++) begin : g_word
			always_ff @(posedge clk) begin
				if (reset) begin
					nvm[gi] <= `NVM_DEFAULT;
					shadow[gi] <= `NVM_DEFAULT;
				end else begin
					nvm[gi] <= next_nvm[gi];
					shadow[gi] <= next_shadow[gi];
				end
			end
		end
	endgenerate

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	ov_stop_a: assert property (ov_s |=> !drive_enable)
		else $error("drive on during overvoltage");
	lowpwr_stop_a: assert property (low_power |-> !drive_enable)
		else $error("drive on in low power");
	sleep_off_a: assert property (low_power |->
		(serial_enable == !SLEEP_VERSION))
		else $error("serial enable wrong in low power");
	standby_keep_a: assert property (!SLEEP_VERSION |-> regulator_enable)
		else $error("standby dropped regulator");
	enter_qual_a: assert property (state == pwr_nvm_pkg::ST_ACTIVE &&
		next_state == pwr_nvm_pkg::ST_LOWPWR |-> cond && qual == limit - QW'(1))
		else $error("low power entered early");
	unlock_seq_a: assert property (reg_req.wr && host_ok &&
		reg_req.addr == `ADDR_NVM_UNLOCK_KEY && reg_req.wdata == `KEY_OPEN &&
		!key_cleared |=> !unlocked)
		else $error("unlocked without clear key");
	locked_cmd_a: assert property (!unlocked && state == pwr_nvm_pkg::ST_ACTIVE
		|=> state != pwr_nvm_pkg::ST_MASS_WRITE &&
		state != pwr_nvm_pkg::ST_MASS_READ)
		else $error("mass access while locked");
	read_done_a: assert property (state == pwr_nvm_pkg::ST_ACTIVE &&
		next_state == pwr_nvm_pkg::ST_MASS_READ |=> !ready ##7 ready)
		else $error("mass read ready timing");
	reload_a: assert property ($rose(state == pwr_nvm_pkg::ST_RELOAD) |-> ##7
		state == pwr_nvm_pkg::ST_ACTIVE)
		else $error("reload did not finish");
	cov_sleep_c: cover property (low_power ##1 !low_power);
	cov_write_c: cover property (state == pwr_nvm_pkg::ST_MASS_WRITE ##1
		state == pwr_nvm_pkg::ST_ACTIVE);
	cov_ov_c: cover property (drive_enable ##1 !drive_enable && ov_s);
endmodule // power_state_and_eeprom_access

// *** bench/host_model.sv ***
// Host controller model for the register port and speed pin
`timescale 1ns/10ps
`include "pwr_nvm_defines.svh"

module host_model (
	// Clock
	input wire logic clk,
	// Register port
	output pwr_nvm_pkg::reg_req_t reg_req,
	input wire logic [15:0] reg_rdata,
	input wire logic reg_rvalid,
	// Speed pin
	output logic speed_pin_high
);
	initial begin
		reg_req = '0;
		speed_pin_high = 1'h1;
	end

	// pin only ever driven to a defined level
	task automatic set_pin(input logic l);
		speed_pin_high = (l === 1'h1);
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk) #1;
		reg_req.addr = a;
		reg_req.wdata = d;
		reg_req.wr = 1'h1;
		@(posedge clk) #1;
		reg_req.wr = 1'h0;
		// Released lines show the inverse so stale data is never reused
		reg_req.wdata = ~d;
		reg_req.addr = ~a;
	endtask

	task automatic rd(input logic [7:0] a, output logic [15:0] d,
		output logic ok);
		int i;
		ok = 1'h0;
		d = 16'h0000;
		@(posedge clk) #1;
		reg_req.addr = a;
		reg_req.rd = 1'h1;
		@(posedge clk) #1;
		reg_req.rd = 1'h0;
		reg_req.addr = ~a;
		for (i = 0; i < 3 && !ok; i++) begin
			if (reg_rvalid === 1'h1) begin
				ok = 1'h1;
				d = reg_rdata;
			end else
				@(posedge clk) #1;
		end
	endtask

	task automatic unlock();
		wr(`ADDR_NVM_UNLOCK_KEY, `KEY_CLEAR);
		wr(`ADDR_NVM_UNLOCK_KEY, `KEY_OPEN);
	endtask

	// poll ready before relying on a result
	task automatic poll_ready(output logic ok);
		logic [15:0] d;
		logic v;
		int n;
		ok = 1'h0;
		for (n = 0; n < 100 && !ok; n++) begin
			rd(`ADDR_NVM_STATUS, d, v);
			ok = v && (d[`STATUS_READY_BIT] === 1'h1);
		end
	endtask
endmodule // host_model

// *** bench/power_state_and_eeprom_access_test.sv ***
// Self-checking bench for power state and EEPROM access
`timescale 1ns/10ps
`include "pwr_nvm_defines.svh"

module power_state_and_eeprom_access_test;
	// Short qualification and write counts keep the run brief
	localparam int QC = 8;
	localparam int WC = 4;
	logic clk, reset, supply_over, reg_rvalid, speed_pin_high, v;
	logic speed_below_enter, speed_above_exit_standby;
	logic speed_above_exit_sleep, drive_enable, regulator_enable;
	logic serial_enable, low_power;
	logic [15:0] reg_rdata, d;
	logic [15:0] words [7];
	logic [8:0] speed_command_field;
	pwr_nvm_pkg::speed_mode_t speed_mode;
	pwr_nvm_pkg::reg_req_t reg_req;
	pwr_nvm_pkg::motor_code_t phase_resistance_code, bemf_constant_code;
	logic sb_drive, sb_reg, sb_ser, sb_low;
	logic [8:0] sb_field;
	int mismatches, num_checks, cycles, i;

	power_state_and_eeprom_access #(.SLEEP_VERSION(1'h1),
		.ENTER_ANA_CYC(QC), .ENTER_PWM_CYC(QC), .EXIT_ANA_CYC(QC),
		.EXIT_PWM_CYC(QC), .NVM_WRITE_CYC(WC)) DUT (.clk(clk),
		.reset(reset), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .supply_over(supply_over),
		.speed_pin_high(speed_pin_high),
		.speed_below_enter(speed_below_enter),
		.speed_above_exit_standby(speed_above_exit_standby),
		.speed_above_exit_sleep(speed_above_exit_sleep),
		.speed_mode(speed_mode), .drive_enable(drive_enable),
		.regulator_enable(regulator_enable),
		.serial_enable(serial_enable), .low_power(low_power),
		.speed_command_field(speed_command_field),
		.phase_resistance_code(phase_resistance_code),
		.bemf_constant_code(bemf_constant_code));

	// Standby version on the same stimulus; only its outputs are watched
	power_state_and_eeprom_access #(.SLEEP_VERSION(1'h0),
		.ENTER_ANA_CYC(QC), .ENTER_PWM_CYC(QC), .EXIT_ANA_CYC(QC),
		.EXIT_PWM_CYC(QC), .NVM_WRITE_CYC(WC)) SB (.clk(clk),
		.reset(reset), .reg_req(reg_req), .reg_rdata(), .reg_rvalid(),
		.supply_over(supply_over), .speed_pin_high(speed_pin_high),
		.speed_below_enter(speed_below_enter),
		.speed_above_exit_standby(speed_above_exit_standby),
		.speed_above_exit_sleep(speed_above_exit_sleep),
		.speed_mode(speed_mode), .drive_enable(sb_drive),
		.regulator_enable(sb_reg), .serial_enable(sb_ser),
		.low_power(sb_low), .speed_command_field(sb_field),
		.phase_resistance_code(), .bemf_constant_code());

	host_model h (.clk(clk), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .speed_pin_high(speed_pin_high));

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %0t seen %h want %h", $time, seen, exp);
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
		logic [15:0] rv;
		logic ok;
		h.rd(a, rv, ok);
		chk({15'h0, ok}, 16'h0001);
		chk(rv, exp);
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			conclude();
		end
	end

	initial begin
		reset = 1'h1;
		supply_over = 1'h0;
		speed_below_enter = 1'h0;
		speed_above_exit_standby = 1'h0;
		speed_above_exit_sleep = 1'h0;
		speed_mode = pwr_nvm_pkg::MODE_ANALOG;
		mismatches = 0;
		num_checks = 0;
		cycles = 0;
		repeat (5) @(posedge clk);
		#1 reset = 1'h0;
		wait_cyc(10);
		rchk(`ADDR_NVM_STATUS, 16'h0001);
		chk({15'h0, drive_enable}, 16'h0001);
		$display("test reset done");

		supply_over = 1'h1;
		wait_cyc(4);
		chk({15'h0, drive_enable}, 16'h0000);
		supply_over = 1'h0;
		wait_cyc(4);
		chk({15'h0, drive_enable}, 16'h0001);
		$display("test overvoltage done");

		h.wr(`ADDR_MOTOR_CONFIG_FIRST, 16'h1234);
		h.wr(`ADDR_NVM_OP_CONTROL, 16'h0024);
		rchk(`ADDR_NVM_STATUS, 16'h0001);
		h.wr(`ADDR_NVM_OP_CONTROL, 16'h0020);
		wait_cyc(10);
		rchk(`ADDR_MOTOR_CONFIG_FIRST, 16'h1234);
		rchk(8'h97, 16'h0000);
		h.wr(`ADDR_NVM_STATUS, 16'hFFFF);
		rchk(`ADDR_NVM_STATUS, 16'h0001);
		h.unlock();
		rchk(`ADDR_NVM_STATUS, 16'h0003);
		$display("test lock done");

		h.wr(`ADDR_DRIVER_NVM_CONTROL, 16'h8000);
		wait_cyc(1);
		chk({15'h0, drive_enable}, 16'h0000);
		for (i = 0; i < 7; i++) begin
			words[i] = 16'h0A13 + 16'(i) * 16'h1111;
			h.wr(8'(`ADDR_MOTOR_CONFIG_FIRST + i), words[i]);
		end
		chk({9'h0, phase_resistance_code}, {9'h0, words[0][6:0]});
		chk({9'h0, bemf_constant_code}, {9'h0, words[1][6:0]});
		h.wr(`ADDR_NVM_OP_CONTROL, 16'h0024);
		rchk(`ADDR_NVM_STATUS, 16'h0002);
		h.poll_ready(v);
		chk({15'h0, v}, 16'h0001);
		for (i = 0; i < 7; i++)
			h.wr(8'(`ADDR_MOTOR_CONFIG_FIRST + i), ~words[i]);
		h.wr(`ADDR_NVM_OP_CONTROL, 16'h0020);
		h.poll_ready(v);
		chk({15'h0, v}, 16'h0001);
		for (i = 0; i < 7; i++)
			rchk(8'(`ADDR_MOTOR_CONFIG_FIRST + i), words[i]);
		chk({9'h0, bemf_constant_code}, {9'h0, words[1][6:0]});
		h.wr(`ADDR_DRIVER_NVM_CONTROL, 16'h0000);
		wait_cyc(1);
		chk({15'h0, drive_enable}, 16'h0001);
		$display("test mass access done");

		h.wr(`ADDR_SPEED_COMMAND, 16'h0064);
		h.wr(`ADDR_MOTOR_CONFIG_FIRST, 16'h5555);
		chk({7'h0, speed_command_field}, 16'h0064);
		speed_below_enter = 1'h1;
		wait_cyc(QC - 2);
		speed_below_enter = 1'h0;
		wait_cyc(4);
		chk({15'h0, low_power}, 16'h0000);
		speed_below_enter = 1'h1;
		wait_cyc(QC + 6);
		chk({12'h0, low_power, drive_enable, regulator_enable,
			serial_enable}, 16'h0008);
		chk({12'h0, sb_low, sb_drive, sb_reg, sb_ser}, 16'h000B);
		chk({7'h0, sb_field}, 16'h0064);
		chk({7'h0, speed_command_field}, 16'h0000);
		h.rd(`ADDR_NVM_STATUS, d, v);
		chk({15'h0, v}, 16'h0000);
		speed_below_enter = 1'h0;
		speed_above_exit_standby = 1'h1;
		wait_cyc(QC + 6);
		chk({15'h0, low_power}, 16'h0001);
		chk({15'h0, sb_low}, 16'h0000);
		speed_above_exit_sleep = 1'h1;
		wait_cyc(QC + 17);
		chk({15'h0, low_power}, 16'h0000);
		speed_above_exit_sleep = 1'h0;
		speed_above_exit_standby = 1'h0;
		rchk(`ADDR_SPEED_COMMAND, 16'h0000);
		rchk(`ADDR_NVM_STATUS, 16'h0001);
		rchk(`ADDR_MOTOR_CONFIG_FIRST, words[0]);
		$display("test analog sleep done");

		speed_mode = pwr_nvm_pkg::MODE_HOST;
		h.wr(`ADDR_SPEED_COMMAND, 16'h0064);
		h.wr(`ADDR_SPEED_COMMAND, 16'h8064);
		h.set_pin(1'h0);
		wait_cyc(QC + 6);
		chk({15'h0, low_power}, 16'h0000);
		h.wr(`ADDR_SPEED_COMMAND, 16'h8000);
		wait_cyc(QC + 6);
		chk({15'h0, low_power}, 16'h0001);
		chk({15'h0, sb_low}, 16'h0001);
		h.set_pin(1'h1);
		wait_cyc(QC + 17);
		chk({15'h0, low_power}, 16'h0000);
		chk({15'h0, sb_low}, 16'h0001);
		$display("test host sleep done");

		// Pin low first so the second sequence is not woken at once
		h.set_pin(1'h0);
		h.wr(`ADDR_DRIVER_NVM_CONTROL, 16'h8000);
		h.wr(`ADDR_SPEED_COMMAND, 16'h8000);
		h.wr(`ADDR_DRIVER_NVM_CONTROL, 16'h0000);
		h.wr(`ADDR_SPEED_COMMAND, 16'h8000);
		wait_cyc(QC + 6);
		chk({14'h0, low_power, sb_low}, 16'h0003);
		speed_mode = pwr_nvm_pkg::MODE_PWM;
		// steady high level is above every wake duty minimum
		h.set_pin(1'h1);
		wait_cyc(QC + 17);
		chk({14'h0, low_power, sb_low}, 16'h0000);
		h.set_pin(1'h0);
		wait_cyc(QC + 6);
		chk({14'h0, low_power, sb_low}, 16'h0003);
		chk({14'h0, drive_enable, sb_drive}, 16'h0000);
		$display("test sequence two and pwm done");
		conclude();
	end
endmodule // power_state_and_eeprom_access_test
